// ===== hdl/timer16_pkg.sv
package timer16_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map, byte offsets on the plain register port
	localparam logic [7:0] ADDR_CTRL_B_T1 = 8'h4e;
	localparam logic [7:0] ADDR_CTRL_B_T3 = 8'h8a;
	localparam logic [7:0] ADDR_CTRL_A = 8'h00;
	localparam logic [7:0] ADDR_CMP_A_LO = 8'h01;
	localparam logic [7:0] ADDR_CMP_A_HI = 8'h02;
	localparam logic [7:0] ADDR_CAP_LO = 8'h03;
	localparam logic [7:0] ADDR_CAP_HI = 8'h04;
	localparam logic [7:0] ADDR_CNT_LO = 8'h05;
	localparam logic [7:0] ADDR_CNT_HI = 8'h06;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h07;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CTRL_A_MODE_LSB = 0;
	localparam int CTRL_B_CLK_LSB = 0;
	localparam int CTRL_B_MODE_LSB = 3;
	localparam int CTRL_B_RSVD_BIT = 5;
	localparam int CTRL_B_EDGE_BIT = 6;
	localparam int CTRL_B_FILT_BIT = 7;
	localparam int IRQ_OVF_BIT = 0;
	localparam int IRQ_CAP_BIT = 1;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values and fixed limits
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] TOP_MAX = 16'hffff;
	localparam logic [15:0] TOP_8BIT = 16'h00ff;
	localparam logic [15:0] TOP_9BIT = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;
	localparam logic [15:0] BOTTOM = 16'h0000;
	localparam int FILTER_SAMPLES = 4;

	////////////////////////////////////////////////////////////////////////////////
	// Clock source codes
	localparam logic [2:0] CLK_STOP = 3'h0;
	localparam logic [2:0] CLK_DIV1 = 3'h1;
	localparam logic [2:0] CLK_DIV8 = 3'h2;
	localparam logic [2:0] CLK_DIV64 = 3'h3;
	localparam logic [2:0] CLK_DIV256 = 3'h4;
	localparam logic [2:0] CLK_DIV1024 = 3'h5;
	localparam logic [2:0] CLK_EXT_FALL = 3'h6;
	localparam logic [2:0] CLK_EXT_RISE = 3'h7;

	// Where the compare register reloads and where overflow is flagged
	typedef enum {EV_IMMEDIATE, EV_TOP, EV_BOTTOM, EV_MAX} event_point_e;

endpackage : timer16_pkg

// ===== hdl/capture_filter.sv
`timescale 1ns/1ps

// Capture pin filter and edge detector
module capture_filter (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Control
	input wire logic filter_en,
	input wire logic edge_rising,
	input wire logic enable,
	// Pin and event
	input wire logic capture_pin,
	output logic capture_event
);

	typedef struct packed {
		logic [3:0] hist;
		logic filt;
		logic prev;
		logic evt;
	} cf_s;

	cf_s st_r;
	cf_s st_nxt;
	logic cur;

	////////////////////////////////////////////////////////////////////////////////
	// Shift in samples; filtered level moves only on four equal ones
	always_comb begin
		st_nxt = st_r;
		st_nxt.hist = {st_r.hist[2:0], capture_pin};
		if (st_nxt.hist == {timer16_pkg::FILTER_SAMPLES{1'b1}}) begin
			st_nxt.filt = 1'b1;
		end else if (st_nxt.hist == {timer16_pkg::FILTER_SAMPLES{1'b0}}) begin
			st_nxt.filt = 1'b0;
		end
		cur = filter_en ? st_r.filt : st_r.hist[0];
		st_nxt.prev = cur;
		// Edge choice: one rising, zero falling
		st_nxt.evt = enable && (edge_rising ? (cur && !st_r.prev) : (!cur && st_r.prev));
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign capture_event = st_r.evt;

endmodule : capture_filter

// ===== hdl/clock_select.sv
`timescale 1ns/1ps

// Prescaler and external count pin edge detect
module clock_select (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Control
	input wire logic [2:0] clock_src_sel,
	// External count pin
	input wire logic ext_count_pin,
	// Count tick
	output logic count_tick
);

	typedef struct packed {
		logic [9:0] pre;
		logic [1:0] ext;
		logic tick;
	} cs_s;

	cs_s st_r;
	cs_s st_nxt;

	// Tick when the low bits of the prescaler wrap
	function automatic logic pre_wrap(input logic [9:0] p, input logic [9:0] m);
		pre_wrap = (p & m) == m;
	endfunction : pre_wrap

	////////////////////////////////////////////////////////////////////////////////
	// Pin is sampled regardless of its direction, so software toggling counts
	always_comb begin
		st_nxt = st_r;
		st_nxt.pre = st_r.pre + 10'h001;
		st_nxt.ext = {st_r.ext[0], ext_count_pin};
		case (clock_src_sel)
			timer16_pkg::CLK_STOP: st_nxt.tick = 1'b0;
			timer16_pkg::CLK_DIV1: st_nxt.tick = 1'b1;
			timer16_pkg::CLK_DIV8: st_nxt.tick = pre_wrap(st_r.pre, 10'h007);
			timer16_pkg::CLK_DIV64: st_nxt.tick = pre_wrap(st_r.pre, 10'h03f);
			timer16_pkg::CLK_DIV256: st_nxt.tick = pre_wrap(st_r.pre, 10'h0ff);
			timer16_pkg::CLK_DIV1024: st_nxt.tick = pre_wrap(st_r.pre, 10'h3ff);
			timer16_pkg::CLK_EXT_FALL: st_nxt.tick = st_r.ext[1] && !st_r.ext[0];
			default: st_nxt.tick = !st_r.ext[1] && st_r.ext[0];
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign count_tick = st_r.tick;

endmodule : clock_select

// ===== hdl/timer16_mode_capture_clock_select.sv
`timescale 1ns/1ps

// Notes on behaviour
// - The wave mode is two bits of control A below two bits of control B.
// - Mode 0 counts to 0xFFFF, loads compare at once and flags overflow at MAX.
// - Modes 1-3 top at 0x00FF/0x01FF/0x03FF, 10/11 use capture or compare A, reload at TOP, flag at BOTTOM.
// - Mode 4 tops at compare A, mode 12 at capture, immediate load, flag at MAX.
// - Modes 5-7 fixed tops, 14/15 capture or compare A, reload at BOTTOM, flag at TOP.
// - Mode 8 tops at capture, mode 9 at compare A, reload and flag at BOTTOM.
// - With the filter on, the capture level changes only after four equal samples.
// - Edge select zero captures on falling edges, one on rising edges.
// - A capture copies the counter into the capture register and sets the capture flag.
// - Modes using the capture register as TOP ignore the capture pin.
// - Clock code 0 stops, codes 1-5 divide the system clock by 1, 8, 64, 256, 1024.
// - Code 6 counts falling and code 7 rising edges of the external count pin.
// - External edges count even when the pin is an output.
module timer16_mode_capture_clock_select (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Pins
	input wire logic capture_pin,
	input wire logic ext_count_pin,
	// Interrupt and status
	output logic irq,
	output logic overflow_flag,
	output logic capture_flag
);

	typedef struct packed {
		logic [7:0] control_register_a;
		logic [7:0] control_register_b;
		logic [15:0] compare_a_reg;
		logic [15:0] compare_a_buf;
		logic [15:0] capture_reg;
		logic [15:0] count;
		logic down;
		logic [7:0] cmp_hi_tmp;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic [7:0] rdata;
		logic irq;
	} top_s;

	top_s st_r;
	top_s st_nxt;
	logic [3:0] wave_mode_sel;
	logic [15:0] top_val;
	logic dual_slope;
	logic cap_is_top;
	timer16_pkg::event_point_e upd_at;
	timer16_pkg::event_point_e ovf_at;
	logic tick;
	logic cap_evt;
	logic at_top;
	logic at_bottom;
	logic ovf_evt;
	logic upd_evt;
	logic [1:0] set_bits;
	logic [1:0] clr_bits;

	////////////////////////////////////////////////////////////////////////////////
	// Mode field assembly
	assign wave_mode_sel = {
		st_r.control_register_b[timer16_pkg::CTRL_B_MODE_LSB +: 2],
		st_r.control_register_a[timer16_pkg::CTRL_A_MODE_LSB +: 2]
	};

	////////////////////////////////////////////////////////////////////////////////
	// Mode table: TOP source, slope, reload and overflow points
	always_comb begin
		top_val = timer16_pkg::TOP_MAX;
		dual_slope = 1'b0;
		cap_is_top = 1'b0;
		upd_at = timer16_pkg::EV_IMMEDIATE;
		ovf_at = timer16_pkg::EV_MAX;
		case (wave_mode_sel)
			4'h0: begin
				top_val = timer16_pkg::TOP_MAX;
			end
			4'h1, 4'h2, 4'h3, 4'ha, 4'hb: begin
				dual_slope = 1'b1;
				upd_at = timer16_pkg::EV_TOP;
				ovf_at = timer16_pkg::EV_BOTTOM;
				if (wave_mode_sel == 4'h1) begin
					top_val = timer16_pkg::TOP_8BIT;
				end else if (wave_mode_sel == 4'h2) begin
					top_val = timer16_pkg::TOP_9BIT;
				end else if (wave_mode_sel == 4'h3) begin
					top_val = timer16_pkg::TOP_10BIT;
				end else if (wave_mode_sel == 4'ha) begin
					top_val = st_r.capture_reg;
					cap_is_top = 1'b1;
				end else begin
					top_val = st_r.compare_a_reg;
				end
			end
			4'h4: begin
				top_val = st_r.compare_a_reg;
			end
			4'hc: begin
				top_val = st_r.capture_reg;
				cap_is_top = 1'b1;
			end
			4'h5, 4'h6, 4'h7, 4'he, 4'hf: begin
				upd_at = timer16_pkg::EV_BOTTOM;
				ovf_at = timer16_pkg::EV_TOP;
				if (wave_mode_sel == 4'h5) begin
					top_val = timer16_pkg::TOP_8BIT;
				end else if (wave_mode_sel == 4'h6) begin
					top_val = timer16_pkg::TOP_9BIT;
				end else if (wave_mode_sel == 4'h7) begin
					top_val = timer16_pkg::TOP_10BIT;
				end else if (wave_mode_sel == 4'he) begin
					top_val = st_r.capture_reg;
					cap_is_top = 1'b1;
				end else begin
					top_val = st_r.compare_a_reg;
				end
			end
			4'h8, 4'h9: begin
				dual_slope = 1'b1;
				upd_at = timer16_pkg::EV_BOTTOM;
				ovf_at = timer16_pkg::EV_BOTTOM;
				if (wave_mode_sel == 4'h8) begin
					top_val = st_r.capture_reg;
					cap_is_top = 1'b1;
				end else begin
					top_val = st_r.compare_a_reg;
				end
			end
			default: begin
				// Mode 13 behaves as normal counting; software avoids it
				top_val = timer16_pkg::TOP_MAX;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Count tick source and capture front end
	clock_select u_clock_select (
		.clk_sys(clk_sys),
		.rst(rst),
		.clock_src_sel(st_r.control_register_b[timer16_pkg::CTRL_B_CLK_LSB +: 3]),
		.ext_count_pin(ext_count_pin),
		.count_tick(tick)
	);

	capture_filter u_capture_filter (
		.clk_sys(clk_sys),
		.rst(rst),
		.filter_en(st_r.control_register_b[timer16_pkg::CTRL_B_FILT_BIT]),
		.edge_rising(st_r.control_register_b[timer16_pkg::CTRL_B_EDGE_BIT]),
		.enable(!cap_is_top),
		.capture_pin(capture_pin),
		.capture_event(cap_evt)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Event points on each count tick
	always_comb begin
		at_top = (st_r.count >= top_val);
		at_bottom = (st_r.count == timer16_pkg::BOTTOM);
		ovf_evt = 1'b0;
		upd_evt = 1'b0;
		if (tick) begin
			case (ovf_at)
				timer16_pkg::EV_MAX: ovf_evt = (st_r.count == timer16_pkg::TOP_MAX);
				timer16_pkg::EV_TOP: ovf_evt = at_top;
				timer16_pkg::EV_BOTTOM: ovf_evt = st_r.down && (st_r.count == 16'h0001);
				default: ovf_evt = 1'b0;
			endcase
			case (upd_at)
				timer16_pkg::EV_TOP: upd_evt = dual_slope ? (!st_r.down && at_top) : at_top;
				timer16_pkg::EV_BOTTOM: upd_evt = dual_slope ? at_bottom : at_top;
				default: upd_evt = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state: counter, registers, interrupt flags, read data
	always_comb begin
		st_nxt = st_r;
		set_bits = '0;
		clr_bits = '0;
		// Counting
		if (tick) begin
			if (dual_slope) begin
				if (!st_r.down && at_top) begin
					st_nxt.down = 1'b1;
					st_nxt.count = st_r.count - 16'h0001;
				end else if (st_r.down && at_bottom) begin
					st_nxt.down = 1'b0;
					st_nxt.count = st_r.count + 16'h0001;
				end else if (st_r.down) begin
					st_nxt.count = st_r.count - 16'h0001;
				end else begin
					st_nxt.count = st_r.count + 16'h0001;
				end
			end else begin
				st_nxt.down = 1'b0;
				st_nxt.count = at_top ? timer16_pkg::BOTTOM : st_r.count + 16'h0001;
			end
		end
		if (upd_evt) begin
			st_nxt.compare_a_reg = st_r.compare_a_buf;
		end
		if (ovf_evt) begin
			set_bits[timer16_pkg::IRQ_OVF_BIT] = 1'b1;
		end
		if (cap_evt) begin
			st_nxt.capture_reg = st_r.count;
			set_bits[timer16_pkg::IRQ_CAP_BIT] = 1'b1;
		end
		// Register writes
		if (reg_wr) begin
			if (reg_addr == timer16_pkg::ADDR_CTRL_A) begin
				st_nxt.control_register_a = reg_wdata;
			end else if (reg_addr == timer16_pkg::ADDR_CTRL_B_T1 ||
					reg_addr == timer16_pkg::ADDR_CTRL_B_T3) begin
				st_nxt.control_register_b = reg_wdata;
				st_nxt.control_register_b[timer16_pkg::CTRL_B_RSVD_BIT] = 1'b0;
			end else if (reg_addr == timer16_pkg::ADDR_CMP_A_HI) begin
				st_nxt.cmp_hi_tmp = reg_wdata;
			end else if (reg_addr == timer16_pkg::ADDR_CMP_A_LO) begin
				st_nxt.compare_a_buf = {st_r.cmp_hi_tmp, reg_wdata};
				if (upd_at == timer16_pkg::EV_IMMEDIATE) begin
					st_nxt.compare_a_reg = {st_r.cmp_hi_tmp, reg_wdata};
				end
			end else if (reg_addr == timer16_pkg::ADDR_CNT_LO) begin
				st_nxt.count = {st_r.count[15:8], reg_wdata};
			end else if (reg_addr == timer16_pkg::ADDR_CNT_HI) begin
				st_nxt.count = {reg_wdata, st_r.count[7:0]};
			end else if (reg_addr == timer16_pkg::ADDR_IRQ_STAT) begin
				clr_bits = reg_wdata[1:0];
			end else if (reg_addr == timer16_pkg::ADDR_IRQ_MASK) begin
				st_nxt.irq_mask = reg_wdata[1:0];
			end
		end
		// Set wins over a simultaneous write-one clear
		st_nxt.irq_stat = (st_r.irq_stat & ~clr_bits) | set_bits;
		st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
		// Read data, valid the cycle after the strobe
		st_nxt.rdata = 8'h00;
		if (reg_rd) begin
			if (reg_addr == timer16_pkg::ADDR_CTRL_A) begin
				st_nxt.rdata = st_r.control_register_a;
			end else if (reg_addr == timer16_pkg::ADDR_CTRL_B_T1 ||
					reg_addr == timer16_pkg::ADDR_CTRL_B_T3) begin
				st_nxt.rdata = st_r.control_register_b;
			end else if (reg_addr == timer16_pkg::ADDR_CMP_A_LO) begin
				st_nxt.rdata = st_r.compare_a_reg[7:0];
			end else if (reg_addr == timer16_pkg::ADDR_CMP_A_HI) begin
				st_nxt.rdata = st_r.compare_a_reg[15:8];
			end else if (reg_addr == timer16_pkg::ADDR_CAP_LO) begin
				st_nxt.rdata = st_r.capture_reg[7:0];
			end else if (reg_addr == timer16_pkg::ADDR_CAP_HI) begin
				st_nxt.rdata = st_r.capture_reg[15:8];
			end else if (reg_addr == timer16_pkg::ADDR_CNT_LO) begin
				st_nxt.rdata = st_r.count[7:0];
			end else if (reg_addr == timer16_pkg::ADDR_CNT_HI) begin
				st_nxt.rdata = st_r.count[15:8];
			end else if (reg_addr == timer16_pkg::ADDR_IRQ_STAT) begin
				st_nxt.rdata = {6'h00, st_r.irq_stat};
			end else if (reg_addr == timer16_pkg::ADDR_IRQ_MASK) begin
				st_nxt.rdata = {6'h00, st_r.irq_mask};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign irq = st_r.irq;
	assign overflow_flag = st_r.irq_stat[timer16_pkg::IRQ_OVF_BIT];
	assign capture_flag = st_r.irq_stat[timer16_pkg::IRQ_CAP_BIT];

endmodule : timer16_mode_capture_clock_select

// ===== verif/timer16_chk_sva.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Port-level checker for the timer control block
module timer16_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Pins
	input wire logic capture_pin,
	input wire logic ext_count_pin,
	// Interrupt and status
	input wire logic irq,
	input wire logic overflow_flag,
	input wire logic capture_flag
);
	logic [7:0] ctl_a_r;
	logic [7:0] ctl_b_r;
	logic [7:0] mask_r;
	logic [3:0] stop_r;
	logic [3:0] quiet_r;
	logic [3:0] top_r;
	logic cap_q_r;
	logic [3:0] mode_t;
	logic cap_top;
	logic [1:0] pend_t;

	// Decoded view of the shadowed settings
	assign mode_t = {ctl_b_r[4:3], ctl_a_r[1:0]};
	assign cap_top = (mode_t == 4'h8) || (mode_t == 4'ha) || (mode_t == 4'hc) || (mode_t == 4'he);
	assign pend_t = {capture_flag, overflow_flag} & mask_r[1:0];

	// Saturating cycle count, cleared while the condition is absent
	function automatic logic [3:0] sat(input logic clr, input logic [3:0] v);
		return clr ? 4'h0 : ((v == 4'hf) ? v : v + 4'h1);
	endfunction : sat

	// Shadow copies of software settings and quiet-time counters
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctl_a_r <= 8'h00;
			ctl_b_r <= 8'h00;
			mask_r <= 8'h00;
			stop_r <= 4'h0;
			quiet_r <= 4'h0;
			top_r <= 4'h0;
			cap_q_r <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == timer16_pkg::ADDR_CTRL_A)
				ctl_a_r <= reg_wdata;
			if (reg_wr && (reg_addr == timer16_pkg::ADDR_CTRL_B_T1 ||
				reg_addr == timer16_pkg::ADDR_CTRL_B_T3))
				ctl_b_r <= reg_wdata & 8'hdf;
			if (reg_wr && reg_addr == timer16_pkg::ADDR_IRQ_MASK)
				mask_r <= reg_wdata;
			stop_r <= sat(ctl_b_r[2:0] != 3'h0, stop_r);
			quiet_r <= sat(capture_pin != cap_q_r, quiet_r);
			top_r <= sat(!cap_top, top_r);
			cap_q_r <= capture_pin;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_no_pend;
		pend_t == 2'b00;
	endsequence
	sequence s_fall_clean;
		// Pin high three samples, so an earlier rising capture has already landed
		$fell(capture_pin) && $past(capture_pin, 2) && $past(capture_pin, 3) &&
			!capture_flag && ctl_b_r[6] && !ctl_b_r[7] && !cap_top;
	endsequence

	property p_ctrl_b_read;
		reg_rd && (reg_addr == timer16_pkg::ADDR_CTRL_B_T1 ||
			reg_addr == timer16_pkg::ADDR_CTRL_B_T3) |=> reg_rdata == ctl_b_r;
	endproperty
	a_ctrl_b_read: assert property (p_ctrl_b_read) else $error("control B readback wrong");
	property p_mode_a_read;
		reg_rd && reg_addr == timer16_pkg::ADDR_CTRL_A |=> reg_rdata[1:0] == ctl_a_r[1:0];
	endproperty
	a_mode_a_read: assert property (p_mode_a_read) else $error("mode bits readback wrong");
	property p_irq_on;
		pend_t != 2'b00 |-> ##[0:1] irq;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("interrupt missing");
	property p_irq_off;
		s_no_pend ##1 s_no_pend |-> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt without cause");
	property p_cap_rise;
		// Pin sample, edge register and event register: flag shows three samples later
		$rose(capture_pin) && ctl_b_r[6] && !ctl_b_r[7] && !cap_top |-> ##3 capture_flag;
	endproperty
	a_cap_rise: assert property (p_cap_rise) else $error("rising edge not captured");
	property p_cap_ignored;
		s_fall_clean ##1 !capture_pin [*2] |-> !capture_flag ##1 !capture_flag;
	endproperty
	a_cap_ignored: assert property (p_cap_ignored) else $error("wrong edge captured");
	property p_cap_top_off;
		top_r >= 4'h8 |-> !$rose(capture_flag);
	endproperty
	a_cap_top_off: assert property (p_cap_top_off) else $error("capture while pin is off");
	property p_filter_hold;
		ctl_b_r[7] && quiet_r >= 4'h8 && $changed(capture_pin) && !capture_flag
			|=> !capture_flag [*4];
	endproperty
	a_filter_hold: assert property (p_filter_hold) else $error("filter passed too early");
	property p_stop;
		stop_r >= 4'h4 |-> !$rose(overflow_flag);
	endproperty
	a_stop: assert property (p_stop) else $error("overflow with clock stopped");
endmodule : timer16_chk

bind timer16_mode_capture_clock_select timer16_chk chk (.clk_sys(clk_sys), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .capture_pin(capture_pin), .ext_count_pin(ext_count_pin),
	.irq(irq), .overflow_flag(overflow_flag), .capture_flag(capture_flag));

// ===== verif/pin_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Far side: event source on the capture pin and count source on the ext pin
module pin_model (
	// Clock
	input wire logic clk_sys,
	// Levels asked for by the bench
	input wire logic cap_req,
	input wire logic ext_req,
	// Pins toward the timer
	output logic capture_pin,
	output logic ext_count_pin
);
	// Pins move just after an edge, like any synchronous source
	always_ff @(posedge clk_sys) begin
		capture_pin <= cap_req;
		ext_count_pin <= ext_req;
	end
endmodule : pin_model

// ===== verif/timer16_mode_capture_clock_select_test.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the timer control block
module timer16_mode_capture_clock_select_test;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic cap_req = 1'b0;
	logic ext_req = 1'b0;
	logic [7:0] reg_rdata;
	logic capture_pin;
	logic ext_count_pin;
	logic irq;
	logic overflow_flag;
	logic capture_flag;
	logic [7:0] rv;
	logic [1:0] cfg = 2'b00;
	int bad_count = 0;
	int n_tests = 0;

	// Clock
	initial forever #25 clk_sys = ~clk_sys;

	timer16_mode_capture_clock_select DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.capture_pin(capture_pin), .ext_count_pin(ext_count_pin), .irq(irq),
		.overflow_flag(overflow_flag), .capture_flag(capture_flag));
	pin_model far (.clk_sys(clk_sys), .cap_req(cap_req), .ext_req(ext_req),
		.capture_pin(capture_pin), .ext_count_pin(ext_count_pin));

	////////////////////////////////////////////////////////////////////////////////
	// Bus cycles and helpers
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask : rd
	task automatic setm(input logic [3:0] m, input logic [2:0] cs);
		wr(timer16_pkg::ADDR_CTRL_A, {6'h00, m[1:0]});
		wr(timer16_pkg::ADDR_CTRL_B_T1, {cfg, 1'b0, m[3:2], cs});
	endtask : setm
	task automatic cnt(input logic [15:0] v);
		wr(timer16_pkg::ADDR_CNT_LO, v[7:0]);
		wr(timer16_pkg::ADDR_CNT_HI, v[15:8]);
	endtask : cnt
	task automatic pin(input logic c, input logic e);
		@(posedge clk_sys);
		cap_req <= c;
		ext_req <= e;
		cyc(8);
	endtask : pin

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_regs;
		rd(timer16_pkg::ADDR_CTRL_B_T1);
		chk(rv, 8'h00);
		wr(timer16_pkg::ADDR_CTRL_B_T3, 8'hff);
		rd(timer16_pkg::ADDR_CTRL_B_T1);
		chk(rv, 8'hdf);
		wr(8'h99, 8'h5a);
		rd(8'h99);
		chk(rv, 8'h00);
		wr(timer16_pkg::ADDR_CTRL_B_T1, 8'h00);
	endtask : t_regs
	task automatic t_presc;
		int dv [5] = '{1, 8, 64, 256, 1024};
		for (int i = 0; i < 5; i++) begin
			setm(4'h0, 3'h0);
			cnt(16'h0000);
			setm(4'h0, 3'(i + 1));
			// Start and stop writes bracket exactly three prescaler periods of ticks
			cyc(3 * dv[i] - 2);
			wr(timer16_pkg::ADDR_CTRL_B_T1, 8'h00);
			rd(timer16_pkg::ADDR_CNT_LO);
			chk(rv, 8'h03);
		end
	endtask : t_presc
	task automatic t_ovf;
		setm(4'h0, 3'h0);
		wr(timer16_pkg::ADDR_IRQ_STAT, 8'h03);
		cnt(16'hfffa);
		setm(4'h0, 3'h1);
		cyc(12);
		setm(4'h0, 3'h0);
		chk(8'(overflow_flag), 8'h01);
		chk(8'(irq), 8'h00);
		wr(timer16_pkg::ADDR_IRQ_MASK, 8'h01);
		cyc(1);
		chk(8'(irq), 8'h01);
		wr(timer16_pkg::ADDR_IRQ_STAT, 8'h01);
		cyc(1);
		chk(8'({irq, overflow_flag}), 8'h00);
		wr(timer16_pkg::ADDR_IRQ_MASK, 8'h00);
	endtask : t_ovf
	task automatic t_modes;
		logic [3:0] md [10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hb, 4'hf};
		logic [15:0] tp [10] = '{16'h00ff, 16'h01ff, 16'h03ff, 16'h0040, 16'h00ff, 16'h01ff,
			16'h03ff, 16'h0040, 16'h0040, 16'h0040};
		logic [9:0] fast = 10'h270;
		logic [9:0] wrap = 10'h278;
		// Mode 13 is reserved and never selected
		// Compare A loaded while in normal mode, so it takes effect at once
		wr(timer16_pkg::ADDR_CMP_A_HI, 8'h00);
		wr(timer16_pkg::ADDR_CMP_A_LO, 8'h40);
		for (int i = 0; i < 10; i++) begin
			// A short normal-mode run clears a down-count left by a dual-slope mode
			setm(4'h0, 3'h1);
			setm(4'h0, 3'h0);
			wr(timer16_pkg::ADDR_IRQ_STAT, 8'h01);
			cnt(tp[i] - 16'h0008);
			setm(md[i], 3'h1);
			cyc(12);
			setm(md[i], 3'h0);
			chk(8'(overflow_flag), 8'(fast[i]));
			rd(timer16_pkg::ADDR_CNT_LO);
			chk(8'(wrap[i] ? rv < 8'h10 : (rv >= tp[i][7:0] - 8'h10 && rv <= tp[i][7:0])),
				8'h01);
		end
		setm(4'h0, 3'h0);
	endtask : t_modes
	task automatic t_ext;
		cnt(16'h0000);
		setm(4'h0, 3'h7);
		repeat (5) begin
			pin(1'b0, 1'b1);
			pin(1'b0, 1'b0);
		end
		rd(timer16_pkg::ADDR_CNT_LO);
		chk(rv, 8'h05);
		setm(4'h0, 3'h6);
		pin(1'b0, 1'b1);
		rd(timer16_pkg::ADDR_CNT_LO);
		chk(rv, 8'h05);
		pin(1'b0, 1'b0);
		rd(timer16_pkg::ADDR_CNT_LO);
		chk(rv, 8'h06);
		setm(4'h0, 3'h0);
	endtask : t_ext
	task automatic t_cap;
		cfg = 2'b01;
		setm(4'h0, 3'h0);
		cnt(16'h1234);
		wr(timer16_pkg::ADDR_IRQ_STAT, 8'h02);
		wr(timer16_pkg::ADDR_IRQ_MASK, 8'h02);
		pin(1'b1, 1'b0);
		chk(8'({irq, capture_flag}), 8'h03);
		rd(timer16_pkg::ADDR_CAP_LO);
		chk(rv, 8'h34);
		rd(timer16_pkg::ADDR_CAP_HI);
		chk(rv, 8'h12);
		wr(timer16_pkg::ADDR_IRQ_STAT, 8'h02);
		pin(1'b0, 1'b0);
		chk(8'(capture_flag), 8'h00);
		cfg = 2'b00;
		setm(4'h0, 3'h0);
		pin(1'b1, 1'b0);
		chk(8'(capture_flag), 8'h00);
		pin(1'b0, 1'b0);
		chk(8'(capture_flag), 8'h01);
		wr(timer16_pkg::ADDR_IRQ_STAT, 8'h02);
		setm(4'hc, 3'h0);
		cyc(8);
		pin(1'b1, 1'b0);
		pin(1'b0, 1'b0);
		chk(8'(capture_flag), 8'h00);
		cfg = 2'b10;
		setm(4'h0, 3'h0);
		pin(1'b1, 1'b0);
		// One-cycle low glitch must not get through the filter
		@(posedge clk_sys);
		cap_req <= 1'b0;
		pin(1'b1, 1'b0);
		chk(8'(capture_flag), 8'h00);
		pin(1'b0, 1'b0);
		chk(8'(capture_flag), 8'h01);
		wr(timer16_pkg::ADDR_IRQ_STAT, 8'h02);
		wr(timer16_pkg::ADDR_IRQ_MASK, 8'h00);
	endtask : t_cap

	////////////////////////////////////////////////////////////////////////////////
	// Verdict, main sequence and watchdog
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test

	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		t_regs;
		t_presc;
		t_ovf;
		t_modes;
		t_ext;
		t_cap;
		end_of_test;
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		end_of_test;
	end
endmodule : timer16_mode_capture_clock_select_test
